// ---- hw/bbcd_consts.vh ----
`ifndef BBCD_CONSTS_VH
`define BBCD_CONSTS_VH

// ************************************************************
// widths and stack depth
// ************************************************************
`define BBCD_PC_W        12
`define BBCD_STACK_DEPTH 6

// ************************************************************
// opcode fields
// ************************************************************
`define BBCD_SENSE_BIT   4
`define BBCD_DISP5_MSB   7
`define BBCD_DISP5_LSB   3

// ************************************************************
// low-bit class codes
// ************************************************************
`define BBCD_LO3_ZCLR    3'h0
`define BBCD_LO3_CCLR    3'h2
`define BBCD_LO3_ZSET    3'h4
`define BBCD_LO3_CSET    3'h6
`define BBCD_LO4_CALL    4'h1
`define BBCD_LO4_JUMP    4'h9
`define BBCD_LO4_BTEST   4'h3
`define BBCD_LO4_BMOD    4'hb

// ************************************************************
// control opcodes
// ************************************************************
`define BBCD_OP_SUB_EXIT 8'hcd
`define BBCD_OP_INT_EXIT 8'h4d
`define BBCD_OP_STOP     8'h6d
`define BBCD_OP_WAIT     8'hed

// ************************************************************
// instruction lengths in bytes
// ************************************************************
`define BBCD_LEN_ONE     12'h001
`define BBCD_LEN_TWO     12'h002
`define BBCD_LEN_THREE   12'h003

`endif

// ---- hw/bbcd_ret_stack.v ----
`timescale 1ns/1ns
`include "bbcd_consts.vh"

module bbcd_ret_stack #(
    parameter WIDTH = `BBCD_PC_W,
    parameter DEPTH = `BBCD_STACK_DEPTH
) (
    // clock and reset
    input  wire             i_clk,
    input  wire             i_sys_rst,
    // push and pop
    input  wire             i_push,
    input  wire             i_pop,
    input  wire [WIDTH-1:0] i_data,
    output wire [WIDTH-1:0] o_top
);

    localparam [2:0] LAST = DEPTH - 1;

    reg [WIDTH-1:0] mem_q [0:DEPTH-1];
    reg [2:0]       ptr_q;
    wire [2:0]      ptr_dec;
    wire [2:0]      ptr_inc;

    // ************************************************************
    // circular pointer, oldest entry lost on overflow
    // ************************************************************
    assign ptr_dec = (ptr_q == 3'h0) ? LAST : ptr_q - 3'h1;
    assign ptr_inc = (ptr_q == LAST) ? 3'h0 : ptr_q + 3'h1;
    assign o_top   = mem_q[ptr_dec];

    always @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
            ptr_q <= 3'h0;
        else if (i_push)
            ptr_q <= ptr_inc;
        else if (i_pop)
            ptr_q <= ptr_dec;
    end

    always @(posedge i_clk)
    begin
        if (i_push)
            mem_q[ptr_q] <= i_data;
    end

endmodule

// ---- hw/bbcd_core.v ----
// How it works
// - short branches two cycles, flags kept
// - 5-bit signed displacement, reach -15..+16
// - bit-test branch three bytes, five cycles
// - 8-bit displacement, reach -126..+129
// - tested bit copied into carry always
// - bit set/clear two bytes, four cycles
// - exit ops two cycles, stop/wait halt until wake; interrupt exit sets flags
// - stop acts as wait under watchdog
// - jump/call 12-bit target, four cycles
// - class chosen by opcode low three or four bits; control ops by whole byte
// - bit-test: opcode bit, address, displacement
// - bit set/clear: opcode bit, then address
`timescale 1ns/1ns
`include "bbcd_consts.vh"

module bbcd_core (
    // clock and reset
    input  wire        i_clk,
    input  wire        i_sys_rst,
    // program memory
    input  wire [7:0]  i_pm_data,
    output reg  [11:0] o_pm_addr,
    output reg         o_pm_rd,
    // data space
    input  wire [7:0]  i_ds_rdata,
    output reg  [7:0]  o_ds_addr,
    output reg         o_ds_rd,
    output reg         o_ds_wr,
    output reg  [7:0]  o_ds_wdata,
    // flags
    input  wire        i_int_flag_z,
    input  wire        i_int_flag_c,
    output reg         o_flag_z,
    output reg         o_flag_c,
    // low power
    input  wire        i_wdog_sel,
    input  wire        i_wake,
    output reg         o_wait,
    output reg         o_stop,
    // other instruction groups
    input  wire        i_ext_done,
    input  wire [1:0]  i_ext_len,
    output reg         o_ext_req,
    output reg  [7:0]  o_ext_op
);

    localparam [6:0] ST_FETCH = 7'h01;
    localparam [6:0] ST_DEC   = 7'h02;
    localparam [6:0] ST_B2    = 7'h04;
    localparam [6:0] ST_B3    = 7'h08;
    localparam [6:0] ST_B4    = 7'h10;
    localparam [6:0] ST_HALT  = 7'h20;
    localparam [6:0] ST_EXT   = 7'h40;

    reg  [6:0]  state_q;
    reg  [11:0] pc_q;
    reg  [7:0]  op_q;
    reg  [7:0]  b2_q;
    reg         taken_q;
    reg         push;
    reg         pop;
    wire [11:0] stack_top;
    wire        cur_bit;
    wire [2:0]  sel_op;

    // ************************************************************
    // decoding helpers
    // ************************************************************
    function [2:0] bit_index;
        input [7:0] op;
        begin
            bit_index = {op[5], op[6], op[7]};
        end
    endfunction

    function [11:0] sext8;
        input [7:0] d;
        begin
            sext8 = {{4{d[7]}}, d};
        end
    endfunction

    assign sel_op  = bit_index(op_q);
    assign cur_bit = i_ds_rdata[sel_op];

    // ************************************************************
    // return stack
    // ************************************************************
    always @*
    begin
        push = (state_q == ST_B3) && (op_q[3:0] == `BBCD_LO4_CALL);
        pop  = (state_q == ST_DEC) &&
               ((i_pm_data == `BBCD_OP_SUB_EXIT) || (i_pm_data == `BBCD_OP_INT_EXIT));
    end

    bbcd_ret_stack #(
        .WIDTH (`BBCD_PC_W),
        .DEPTH (`BBCD_STACK_DEPTH)
    ) u_stack (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_push    (push),
        .i_pop     (pop),
        .i_data    (pc_q + `BBCD_LEN_TWO),
        .o_top     (stack_top)
    );

    // ************************************************************
    // next fetch
    // ************************************************************
    task jump_to;
        input [11:0] addr;
        begin
            pc_q      <= addr;
            o_pm_addr <= addr;
            o_pm_rd   <= 1'b1;
            state_q   <= ST_FETCH;
        end
    endtask

    // ************************************************************
    // sequencer
    // ************************************************************
    always @(posedge i_clk or posedge i_sys_rst)
    begin
        if (i_sys_rst)
        begin
            state_q    <= ST_FETCH;
            pc_q       <= 12'h000;
            op_q       <= 8'h00;
            b2_q       <= 8'h00;
            taken_q    <= 1'b0;
            o_pm_addr  <= 12'h000;
            o_pm_rd    <= 1'b1;
            o_ds_addr  <= 8'h00;
            o_ds_rd    <= 1'b0;
            o_ds_wr    <= 1'b0;
            o_ds_wdata <= 8'h00;
            o_flag_z   <= 1'b0;
            o_flag_c   <= 1'b0;
            o_wait     <= 1'b0;
            o_stop     <= 1'b0;
            o_ext_req  <= 1'b0;
            o_ext_op   <= 8'h00;
        end
        else
        begin
            case (state_q)
            ST_FETCH:
            begin
                o_pm_rd <= 1'b0;
                o_ds_wr <= 1'b0;
                state_q <= ST_DEC;
            end
            ST_DEC:
            begin
                op_q <= i_pm_data;
                if (i_pm_data[2:0] == `BBCD_LO3_ZCLR || i_pm_data[2:0] == `BBCD_LO3_CCLR ||
                    i_pm_data[2:0] == `BBCD_LO3_ZSET || i_pm_data[2:0] == `BBCD_LO3_CSET)
                begin
                    if ((i_pm_data[2:0] == `BBCD_LO3_ZCLR && !o_flag_z) ||
                        (i_pm_data[2:0] == `BBCD_LO3_CCLR && !o_flag_c) ||
                        (i_pm_data[2:0] == `BBCD_LO3_ZSET &&  o_flag_z) ||
                        (i_pm_data[2:0] == `BBCD_LO3_CSET &&  o_flag_c))
                        jump_to(pc_q + `BBCD_LEN_ONE + {{7{i_pm_data[`BBCD_DISP5_MSB]}},
                                i_pm_data[`BBCD_DISP5_MSB:`BBCD_DISP5_LSB]});
                    else
                        jump_to(pc_q + `BBCD_LEN_ONE);
                end
                else if (i_pm_data[3:0] == `BBCD_LO4_CALL || i_pm_data[3:0] == `BBCD_LO4_JUMP ||
                         i_pm_data[3:0] == `BBCD_LO4_BTEST || i_pm_data[3:0] == `BBCD_LO4_BMOD)
                begin
                    o_pm_addr <= pc_q + `BBCD_LEN_ONE;
                    o_pm_rd   <= 1'b1;
                    state_q   <= ST_B2;
                end
                else if (i_pm_data == `BBCD_OP_SUB_EXIT)
                    jump_to(stack_top);
                else if (i_pm_data == `BBCD_OP_INT_EXIT)
                begin
                    o_flag_z <= i_int_flag_z;
                    o_flag_c <= i_int_flag_c;
                    jump_to(stack_top);
                end
                else if (i_pm_data == `BBCD_OP_STOP || i_pm_data == `BBCD_OP_WAIT)
                begin
                    pc_q    <= pc_q + `BBCD_LEN_ONE;
                    o_stop  <= (i_pm_data == `BBCD_OP_STOP) && !i_wdog_sel;
                    o_wait  <= (i_pm_data == `BBCD_OP_WAIT) || i_wdog_sel;
                    state_q <= ST_HALT;
                end
                else
                begin
                    o_ext_req <= 1'b1;
                    o_ext_op  <= i_pm_data;
                    state_q   <= ST_EXT;
                end
            end
            ST_B2:
            begin
                b2_q    <= i_pm_data;
                o_pm_rd <= 1'b0;
                state_q <= ST_B3;
                if (op_q[3:0] == `BBCD_LO4_BTEST || op_q[3:0] == `BBCD_LO4_BMOD)
                begin
                    o_ds_addr <= i_pm_data;
                    o_ds_rd   <= 1'b1;
                end
                if (op_q[3:0] == `BBCD_LO4_BTEST)
                begin
                    o_pm_addr <= pc_q + `BBCD_LEN_TWO;
                    o_pm_rd   <= 1'b1;
                end
            end
            ST_B3:
            begin
                o_ds_rd <= 1'b0;
                o_pm_rd <= 1'b0;
                if (op_q[3:0] == `BBCD_LO4_BTEST)
                begin
                    o_flag_c <= cur_bit;
                    taken_q  <= (cur_bit == op_q[`BBCD_SENSE_BIT]);
                    b2_q     <= i_pm_data;
                    state_q  <= ST_B4;
                end
                else if (op_q[3:0] == `BBCD_LO4_BMOD)
                begin
                    o_ds_wr    <= 1'b1;
                    o_ds_wdata <= op_q[`BBCD_SENSE_BIT] ? (i_ds_rdata | (8'h01 << sel_op))
                                                        : (i_ds_rdata & ~(8'h01 << sel_op));
                    jump_to(pc_q + `BBCD_LEN_TWO);
                end
                else
                    jump_to({op_q[7:4], b2_q});
            end
            ST_B4:
            begin
                if (taken_q)
                    jump_to(pc_q + `BBCD_LEN_TWO + sext8(b2_q));
                else
                    jump_to(pc_q + `BBCD_LEN_THREE);
            end
            ST_HALT:
            begin
                if (i_wake)
                begin
                    o_wait <= 1'b0;
                    o_stop <= 1'b0;
                    jump_to(pc_q);
                end
            end
            ST_EXT:
            begin
                if (i_ext_done)
                begin
                    o_ext_req <= 1'b0;
                    jump_to(pc_q + {10'h000, i_ext_len});
                end
            end
            default:
                jump_to(pc_q);
            endcase
        end
    end

endmodule

// ---- verification/bbcd_mem_model.sv ----
`timescale 1ns/1ns
module bbcd_mem_model (
    // clock
    input  wire        i_clk,
    // program side
    input  wire        i_pm_rd,
    input  wire [11:0] i_pm_addr,
    output wire [7:0]  o_pm_data,
    // data side
    input  wire        i_ds_rd,
    input  wire        i_ds_wr,
    input  wire [7:0]  i_ds_addr,
    input  wire [7:0]  i_ds_wdata,
    output wire [7:0]  o_ds_rdata
);
    reg [7:0] pmem [0:4095];
    reg [7:0] dmem [0:255];
    reg       pm_rd_q = 1'b0;
    reg [7:0] pm_last_q = 8'h00;
    reg [7:0] ds_last_q = 8'h00;
    // program byte shown while strobed and one cycle after, data byte only while strobed; inverted when idle
    assign o_pm_data  = (i_pm_rd || pm_rd_q) ? pmem[i_pm_addr] : ~pm_last_q;
    assign o_ds_rdata = i_ds_rd ? dmem[i_ds_addr] : ~ds_last_q;
    always @(posedge i_clk)
    begin
        pm_rd_q   <= i_pm_rd;
        pm_last_q <= o_pm_data;
        ds_last_q <= o_ds_rdata;
        if (i_ds_wr)
            dmem[i_ds_addr] <= i_ds_wdata;
    end
endmodule

// ---- verification/bbcd_checker.sv ----
`timescale 1ns/1ns
module bbcd_checker (
    // clock and reset
    input wire        i_clk,
    input wire        i_sys_rst,
    // memories
    input wire        o_pm_rd,
    input wire [11:0] o_pm_addr,
    input wire [7:0]  i_ds_rdata,
    input wire        o_ds_rd,
    input wire        o_ds_wr,
    input wire [7:0]  o_ds_wdata,
    // halt
    input wire        i_wdog_sel,
    input wire        i_wake,
    input wire        o_wait,
    input wire        o_stop
);
    reg [7:0] cap_q;
    always @(posedge i_clk or posedge i_sys_rst)
        if (i_sys_rst)
            cap_q <= 8'h00;
        else if (o_ds_rd)
            cap_q <= i_ds_rdata;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_sys_rst);
    ds_rd_pulse_a: assert property (o_ds_rd |=> !o_ds_rd)
        else $error("data read strobe too long");
    ds_wr_cause_a: assert property (o_ds_wr |-> $past(o_ds_rd) || $past(o_ds_rd, 2)
        || $past(o_ds_rd, 3)) else $error("write without read");
    ds_one_bit_a: assert property (o_ds_wr |-> $countones(o_ds_wdata ^ cap_q) <= 1)
        else $error("write changes more than one bit");
    pm_burst_a: assert property (o_pm_rd && !i_sys_rst ##1 o_pm_rd
        |-> o_pm_addr == $past(o_pm_addr) + 12'h001)
        else $error("back to back fetch not sequential");
    stop_wdog_a: assert property ($rose(o_stop) |-> !i_wdog_sel)
        else $error("stop under watchdog");
    halt_no_fetch_a: assert property ((o_wait || o_stop) |-> !o_pm_rd)
        else $error("fetch while halted");
    halt_hold_a: assert property ((o_wait || o_stop) && !i_wake |=> o_wait || o_stop)
        else $error("halt left without wake");
    wake_fetch_a: assert property ((o_wait || o_stop) && i_wake |=> ##[0:1] o_pm_rd)
        else $error("no fetch after wake");
    cover property (o_ds_wr);
    cover property ($rose(o_wait));
    cover property ($rose(o_stop));
endmodule
bind bbcd_core bbcd_checker bbcd_checker_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst),
    .o_pm_rd(o_pm_rd), .o_pm_addr(o_pm_addr), .i_ds_rdata(i_ds_rdata), .o_ds_rd(o_ds_rd),
    .o_ds_wr(o_ds_wr), .o_ds_wdata(o_ds_wdata), .i_wdog_sel(i_wdog_sel), .i_wake(i_wake),
    .o_wait(o_wait), .o_stop(o_stop));

// ---- verification/tb.sv ----
`timescale 1ns/1ns
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
    typedef struct packed {
        logic [23:0] code;
        logic [1:0]  zc;
        logic [3:0]  n;
        logic [11:0] a;
        logic        ce;
        logic [7:0]  m;
    } bbcd_row_t;
    logic        i_clk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic        i_int_flag_z = 1'b0;
    logic        i_int_flag_c = 1'b0;
    logic        i_wdog_sel = 1'b0;
    logic        i_wake = 1'b0;
    logic        i_ext_done = 1'b0;
    logic [1:0]  i_ext_len = 2'h2;
    wire  [11:0] o_pm_addr;
    wire  [7:0]  pm_data, ds_rdata, o_ds_addr, o_ds_wdata, o_ext_op;
    wire         o_pm_rd, o_ds_rd, o_ds_wr, o_flag_z, o_flag_c, o_wait, o_stop, o_ext_req;
    int          fail_count = 0;
    int          total_checks = 0;
    int          cycles = 0;
    int          i, k;
    bbcd_row_t   r;
    bbcd_row_t   rows [0:14];
    bbcd_core bbcd_core_i (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_pm_data(pm_data),
        .o_pm_addr(o_pm_addr), .o_pm_rd(o_pm_rd), .i_ds_rdata(ds_rdata), .o_ds_addr(o_ds_addr),
        .o_ds_rd(o_ds_rd), .o_ds_wr(o_ds_wr), .o_ds_wdata(o_ds_wdata),
        .i_int_flag_z(i_int_flag_z), .i_int_flag_c(i_int_flag_c), .o_flag_z(o_flag_z),
        .o_flag_c(o_flag_c), .i_wdog_sel(i_wdog_sel), .i_wake(i_wake), .o_wait(o_wait),
        .o_stop(o_stop), .i_ext_done(i_ext_done), .i_ext_len(i_ext_len), .o_ext_req(o_ext_req),
        .o_ext_op(o_ext_op));
    bbcd_mem_model mem_i (.i_clk(i_clk), .i_pm_rd(o_pm_rd), .i_pm_addr(o_pm_addr),
        .o_pm_data(pm_data), .i_ds_rd(o_ds_rd), .i_ds_wr(o_ds_wr), .i_ds_addr(o_ds_addr),
        .i_ds_wdata(o_ds_wdata), .o_ds_rdata(ds_rdata));
    initial forever #10 i_clk = ~i_clk;
    always @(posedge i_clk)
    begin
        i_ext_done <= o_ext_req & ~i_ext_done;
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            fail_count++;
            close_out;
        end
    end
    task close_out;
        if (fail_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // call 0x010, interrupt exit, then the opcode at 0x002
    task exec(input bbcd_row_t x);
        @(posedge i_clk);
        i_sys_rst <= 1'b1;
        i_int_flag_z <= x.zc[1];
        i_int_flag_c <= x.zc[0];
        {mem_i.pmem[0], mem_i.pmem[1], mem_i.pmem[16]} = 24'h01104d;
        {mem_i.pmem[2], mem_i.pmem[3], mem_i.pmem[4]} = x.code;
        mem_i.dmem[32] = 8'ha5;
        repeat (3) @(posedge i_clk);
        @(negedge i_clk);
        `CHK({o_pm_rd, o_pm_addr, o_flag_z, o_flag_c, o_wait, o_stop}, 17'h10000)
        @(posedge i_clk);
        i_sys_rst <= 1'b0;
        for (k = 0; k <= 6 + x.n; k++)
        begin
            @(negedge i_clk);
            if (k == 4)
                `CHK({o_pm_rd, o_pm_addr}, 13'h1010)
            if (k == 6)
                `CHK({o_pm_rd, o_pm_addr}, 13'h1002)
        end
    endtask
    initial
    begin
        rows = '{{24'h800000, 2'b00, 4'd2, 12'hff3, 1'b0, 8'ha5},
            {24'h780000, 2'b10, 4'd2, 12'h003, 1'b0, 8'ha5},
            {24'h7c0000, 2'b11, 4'd2, 12'h012, 1'b1, 8'ha5},
            {24'h7c0000, 2'b00, 4'd2, 12'h003, 1'b0, 8'ha5},
            {24'h7a0000, 2'b10, 4'd2, 12'h012, 1'b0, 8'ha5},
            {24'h7a0000, 2'b01, 4'd2, 12'h003, 1'b1, 8'ha5},
            {24'h7e0000, 2'b01, 4'd2, 12'h012, 1'b1, 8'ha5},
            {24'h7e0000, 2'b10, 4'd2, 12'h003, 1'b0, 8'ha5},
            {24'h040000, 2'b11, 4'd2, 12'h003, 1'b1, 8'ha5},
            {24'ha93400, 2'b01, 4'd4, 12'ha34, 1'b1, 8'ha5},
            {24'h13207f, 2'b00, 4'd5, 12'h083, 1'b1, 8'ha5},
            {24'h03207f, 2'b10, 4'd5, 12'h005, 1'b1, 8'ha5},
            {24'h832080, 2'b01, 4'd5, 12'hf84, 1'b0, 8'ha5},
            {24'h9b2000, 2'b01, 4'd4, 12'h004, 1'b1, 8'ha7},
            {24'h0b2000, 2'b10, 4'd4, 12'h004, 1'b0, 8'ha4}};
        for (k = 0; k < 4096; k++)
            mem_i.pmem[k] = 8'h04;
        for (i = 0; i < 15; i++)
        begin
            r = rows[i];
            exec(r);
            `CHK({o_pm_rd, o_pm_addr}, {1'b1, r.a})
            `CHK({o_flag_z, o_flag_c}, {r.zc[1], r.ce})
            `CHK(o_ds_addr, (r.code[17:16] == 2'b11) ? 8'h20 : 8'h00)
            repeat (3) @(negedge i_clk);
            `CHK(mem_i.dmem[32], r.m)
        end
        for (i = 0; i < 3; i++)
        begin
            r = {(i == 2) ? 24'hed0000 : 24'h6d0000, 2'b00, 4'd2, 12'h003, 1'b0, 8'ha5};
            @(posedge i_clk);
            i_wdog_sel <= (i == 0);
            exec(r);
            `CHK({o_wait, o_stop, o_pm_rd}, (i == 1) ? 3'b010 : 3'b100)
            repeat (3) @(posedge i_clk);
            i_wake <= 1'b1;
            @(posedge i_clk);
            i_wake <= 1'b0;
            @(negedge i_clk);
            for (k = 0; k < 4 && o_pm_rd !== 1'b1; k++)
                @(negedge i_clk);
            `CHK({o_pm_rd, o_pm_addr, o_wait, o_stop}, {1'b1, 12'h003, 2'b00})
        end
        r = {24'h050000, 2'b00, 4'd2, 12'h004, 1'b0, 8'ha5};
        exec(r);
        `CHK({o_ext_req, o_ext_op}, 9'h105)
        repeat (2) @(negedge i_clk);
        `CHK({o_pm_rd, o_pm_addr, o_ext_req}, {1'b1, r.a, 1'b0})
        close_out;
    end
endmodule
